//--- bench/digital_resistor_serial_control_bench.sv
/*
 * Bench for the resistor controller: frames, wipers, ready and strobe.
 * Assumes the package, controller, host model and checker are compiled.
 */
`timescale 1ns/100ps
`default_nettype none

module digital_resistor_serial_control_bench;
	localparam int STORE_SIM = 200;

	logic       mclk_in            = 1'b0;
	logic       rstn_in            = 1'b0;
	logic       reload_strobe_n_in = 1'b1;
	logic       write_protect_n_in = 1'b1;
	wire        sclk_in;
	wire        cs_n_in;
	wire        sdi_in;
	wire        sdo_line;
	logic       sdo_out;
	logic       sdo_oe_n_out;
	logic       rdy_out;
	logic       rdy_oe_n_out;
	logic [9:0] wiper0_out;
	logic [9:0] wiper1_out;
	int         bad_count = 0;
	int         cmp_count = 0;

	always #25 mclk_in = ~mclk_in;

	assign sdo_line = sdo_oe_n_out ? 1'b1 : sdo_out;

	digital_resistor_serial_control #(.STORE_CYCLES(STORE_SIM)) DUT (
		.mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in),
		.reload_strobe_n_in(reload_strobe_n_in), .write_protect_n_in(write_protect_n_in),
		.sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .rdy_out(rdy_out), .rdy_oe_n_out(rdy_oe_n_out),
		.wiper0_out(wiper0_out), .wiper1_out(wiper1_out)
	);

	spi_host host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in), .sdo_in(sdo_line));

	// ========================================
	// Tasks.
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : close_out

	task automatic check(input string nm, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic ticks(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : ticks

	task automatic wait_rdy;
		int k;
		k = 0;
		while (rdy_oe_n_out !== 1'b1 && k < 1000) begin
			@(negedge mclk_in);
			k++;
		end
		if (k >= 1000) begin
			bad_count++;
			close_out();
		end
	endtask : wait_rdy

	task automatic step(input logic [47:0] w, input int n, input logic [9:0] e0, input logic [9:0] e1);
		host.xfer(w, n);
		ticks(10);
		wait_rdy();
		check("wiper0", {14'h0, e0}, {14'h0, wiper0_out});
		check("wiper1", {14'h0, e1}, {14'h0, wiper1_out});
	endtask : step

	// ========================================
	// Main sequence.
	initial begin
		ticks(2);
		check("reset wiper0", 24'h000200, {14'h0, wiper0_out});
		rstn_in = 1'b1;
		ticks(25);
		check("ready", 24'h000001, {23'h0, rdy_oe_n_out});
		step(48'hb00100, 24, 10'h100, 10'h200);
		step(48'hb1fd55, 24, 10'h100, 10'h155);
		check("sdo echo", 24'hb00100, host.got);
		host.xfer(48'h200000, 24);
		ticks(10);
		check("store busy", 24'h0, {23'h0, rdy_oe_n_out});
		step(48'hb003ff, 24, 10'h100, 10'h155);
		step(48'hb003ff, 24, 10'h3ff, 10'h155);
		step(48'he00000, 24, 10'h3ff, 10'h155);
		step(48'hf00000, 24, 10'h3ff, 10'h156);
		step(48'h100000, 24, 10'h100, 10'h156);
		step(48'h400000, 24, 10'h080, 10'h156);
		step(48'h500000, 24, 10'h040, 10'h0ab);
		step(48'hc10000, 24, 10'h040, 10'h156);
		step(48'hd00000, 24, 10'h080, 10'h2ac);
		step(48'h600000, 24, 10'h07f, 10'h2ac);
		step(48'h710000, 24, 10'h07e, 10'h2ab);
		step(48'hb00000, 24, 10'h000, 10'h2ab);
		step(48'h600000, 24, 10'h000, 10'h2ab);
		step(48'h000000, 24, 10'h000, 10'h2ab);
		step(48'he10000, 24, 10'h000, 10'h2ac);
		step(48'h000000, 0, 10'h000, 10'h2ad);
		step(48'h1b00155, 25, 10'h000, 10'h2ad);
		step(48'hb00011b10022, 48, 10'h000, 10'h022);
		step(48'h35beef, 24, 10'h000, 10'h022);
		step(48'h950000, 24, 10'h000, 10'h022);
		step(48'h000000, 24, 10'h000, 10'h022);
		check("store readback", 24'h95beef, host.got);
		step(48'ha10000, 24, 10'h000, 10'h022);
		step(48'h000000, 24, 10'h000, 10'h022);
		check("wiper readback", 24'ha10022, host.got);
		write_protect_n_in = 1'b0;
		step(48'hb00333, 24, 10'h000, 10'h022);
		step(48'he10000, 24, 10'h000, 10'h022);
		step(48'h800000, 24, 10'h100, 10'h200);
		write_protect_n_in = 1'b1;
		step(48'hb00300, 24, 10'h300, 10'h200);
		reload_strobe_n_in = 1'b0;
		ticks(8);
		check("strobe mid", 24'h000200, {14'h0, wiper0_out});
		reload_strobe_n_in = 1'b1;
		ticks(8);
		check("strobe busy", 24'h0, {23'h0, rdy_oe_n_out});
		wait_rdy();
		check("strobe load", 24'h000100, {14'h0, wiper0_out});
		close_out();
	end
endmodule : digital_resistor_serial_control_bench

`default_nettype wire

//--- bench/dres_checker.sv
/*
 * Port checks on the resistor controller, bound into it.
 * Assumes one system clock domain and an async active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none

module dres_checker #(
	parameter int STORE_CYCLES   = 300000,
	parameter int RESTORE_CYCLES = 16,
	parameter int READ_CYCLES    = 2
) (
	input wire logic       mclk_in,
	input wire logic       rstn_in,
	input wire logic       cs_n_in,
	input wire logic       reload_strobe_n_in,
	input wire logic       sdo_out,
	input wire logic       sdo_oe_n_out,
	input wire logic       rdy_out,
	input wire logic       rdy_oe_n_out,
	input wire logic [9:0] wiper0_out,
	input wire logic [9:0] wiper1_out
);
	int   low_cnt;
	int   cs_age;
	logic booted;

	// ========================================
	// Busy length and select age counters.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			low_cnt <= 0;
			cs_age  <= 100;
			booted  <= 1'b0;
		end else begin
			low_cnt <= rdy_oe_n_out ? 0 : low_cnt + 1;
			cs_age  <= !cs_n_in ? 0 : (cs_age < 100 ? cs_age + 1 : cs_age);
			booted  <= booted | rdy_oe_n_out;
		end
	end

	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rstn_in);

	// ========================================
	// Assertions.
	power_mid_a: assert property (
		$rose(rstn_in) |-> wiper0_out == 10'h200 && wiper1_out == 10'h200 && !rdy_oe_n_out)
		else $error("wipers not midscale after reset");
	sdo_idle_off_a: assert property (cs_n_in |-> sdo_oe_n_out)
		else $error("data out pulled while deselected");
	od_level_a: assert property (sdo_out == 1'b0 && rdy_out == 1'b0)
		else $error("open-drain level not low");
	strobe_mid_a: assert property (
		!reload_strobe_n_in [*6] |-> wiper0_out == 10'h200 && wiper1_out == 10'h200)
		else $error("wipers not midscale under strobe");
	strobe_load_a: assert property (
		$rose(reload_strobe_n_in) && rdy_oe_n_out |-> ##[1:6] !rdy_oe_n_out)
		else $error("strobe release did not start reload");
	quick_accept_a: assert property (
		($changed(wiper0_out) || $changed(wiper1_out)) && $past(rdy_oe_n_out) && $past(rdy_oe_n_out, 2)
		&& reload_strobe_n_in && $past(reload_strobe_n_in, 8) |-> cs_age <= 7)
		else $error("wiper moved without a frame end");
	ready_fall_a: assert property (
		$fell(rdy_oe_n_out) && $past(rdy_oe_n_out, 2) && reload_strobe_n_in && $past(reload_strobe_n_in, 8)
		|-> cs_age <= 7)
		else $error("busy began without a frame end");
	busy_len_a: assert property (
		booted && $rose(rdy_oe_n_out) |->
		low_cnt == READ_CYCLES || low_cnt == RESTORE_CYCLES || low_cnt == STORE_CYCLES)
		else $error("busy period of wrong length");

	cover property ($fell(rdy_oe_n_out));
	cover property ($rose(reload_strobe_n_in));
	cover property ($changed(wiper1_out));
endmodule : dres_checker

bind digital_resistor_serial_control dres_checker #(
	.STORE_CYCLES(STORE_CYCLES), .RESTORE_CYCLES(RESTORE_CYCLES), .READ_CYCLES(READ_CYCLES)
) chk (
	.mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in), .reload_strobe_n_in(reload_strobe_n_in),
	.sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out), .rdy_out(rdy_out), .rdy_oe_n_out(rdy_oe_n_out),
	.wiper0_out(wiper0_out), .wiper1_out(wiper1_out)
);

`default_nettype wire

//--- bench/spi_host.sv
/*
 * Serial host model: sends frames and captures the data-out line.
 * Assumes the bench resolves the open-drain data-out with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none

module spi_host (
	output logic       sclk_out,
	output logic       cs_n_out,
	output logic       sdi_out,
	input  wire logic  sdo_in
);
	logic [23:0] got;

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out  = 1'b0;
		got      = 24'h000000;
	end

	// ========================================
	// Frame transfer.
	// Sends n bits.
	task automatic xfer(input logic [47:0] w, input int n);
		cs_n_out = 1'b0;
		#80;
		for (int i = n - 1; i >= 0; i--) begin
			sdi_out = w[i];
			#80;
			got = {got[22:0], sdo_in};
			sclk_out = 1'b1;
			#80;
			sclk_out = 1'b0;
		end
		#80;
		cs_n_out = 1'b1;
		sdi_out  = ~sdi_out;
		#400;
	endtask : xfer
endmodule : spi_host

`default_nettype wire

//--- logic/digital_resistor_serial_control.sv
/*
 * Command interpreter for a dual-channel digital resistor with a nonvolatile store.
 * Assumes an SPI host on the serial pins and pull-ups on the open-drain outputs.
 */
`timescale 1ns/100ps
`default_nettype none

module digital_resistor_serial_control #(
	parameter int STORE_CYCLES   = dres_pkg::STORE_CYCLES,
	parameter int RESTORE_CYCLES = dres_pkg::RESTORE_CYCLES,
	parameter int READ_CYCLES    = dres_pkg::READ_CYCLES
) (
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	input  wire logic       sclk_in,
	input  wire logic       cs_n_in,
	input  wire logic       sdi_in,
	input  wire logic       reload_strobe_n_in,
	input  wire logic       write_protect_n_in,
	output logic            sdo_out,
	output logic            sdo_oe_n_out,
	output logic            rdy_out,
	output logic            rdy_oe_n_out,
	output logic      [9:0] wiper0_out,
	output logic      [9:0] wiper1_out
);

	localparam int CNT_W = $clog2(STORE_CYCLES + 1);

	// ==========================================================
	// Decoding helpers
	function automatic logic hits(input logic [3:0] cmd, input logic ch, input logic idx);
		logic r;
		r = 1'b0;
		case (dres_pkg::cmd_t'(cmd))
			dres_pkg::CMD_HALVE_ONE, dres_pkg::CMD_DEC_ONE, dres_pkg::CMD_WRITE_WIPER,
			dres_pkg::CMD_DOUBLE_ONE, dres_pkg::CMD_INC_ONE: r = (ch == idx);
			dres_pkg::CMD_HALVE_ALL, dres_pkg::CMD_DEC_ALL,
			dres_pkg::CMD_DOUBLE_ALL, dres_pkg::CMD_INC_ALL: r = 1'b1;
			default: r = 1'b0;
		endcase
		return r;
	endfunction : hits

	function automatic logic [9:0] wiper_op(input logic [3:0] cmd, input logic [9:0] w,
			input logic [15:0] d);
		logic [9:0] r;
		r = w;
		case (dres_pkg::cmd_t'(cmd))
			dres_pkg::CMD_HALVE_ONE, dres_pkg::CMD_HALVE_ALL: r = {1'b0, w[9:1]};
			dres_pkg::CMD_DEC_ONE, dres_pkg::CMD_DEC_ALL:
				r = (w == dres_pkg::WIPER_ZERO) ? w : w - 10'h001;
			dres_pkg::CMD_WRITE_WIPER: r = d[9:0];
			dres_pkg::CMD_DOUBLE_ONE, dres_pkg::CMD_DOUBLE_ALL:
				r = w[9] ? dres_pkg::WIPER_FULL : {w[8:0], 1'b0};
			dres_pkg::CMD_INC_ONE, dres_pkg::CMD_INC_ALL:
				r = (w == dres_pkg::WIPER_FULL) ? w : w + 10'h001;
			default: r = w;
		endcase
		return r;
	endfunction : wiper_op

	// ==========================================================
	// Signals
	logic [23:0]               link_word;
	logic [4:0]                link_cnt;
	logic                      link_tog;
	logic [23:0]               rb_word;
	logic                      rb_valid;
	logic [3:0]                raw;
	logic [3:0]                s1;
	logic [3:0]                s2;
	logic [3:0]                s3;
	logic [3:0]                filt;
	logic [3:0]                next_filt;
	logic [3:0]                rise;
	logic                      cs_rise;
	logic                      pr_rise;
	logic                      pr_low;
	logic                      wp_on;
	logic                      seen_tog;
	logic                      clocked;
	logic                      go;
	logic [23:0]               last_word;
	logic                      last_ok;
	logic [23:0]               cmd_word;
	logic [3:0]                cmd;
	logic [3:0]                addr;
	logic [15:0]               data;
	logic                      ch;
	logic                      store_ok;
	dres_pkg::busy_state_t     state;
	logic [CNT_W-1:0]          busy_cnt;
	logic [1:0]                load_mask;
	logic                      pr_pend;
	logic                      load_done;
	logic                      store_done;
	logic [3:0]                st_addr;
	logic [15:0]               st_data;
	logic [9:0]                wiper [dres_pkg::CHANNELS];
	logic [15:0]               store [dres_pkg::STORE_WORDS];

	// ==========================================================
	// Link-side logic
	serial_link u_link (
		.sclk_in       (sclk_in),
		.rstn_in       (rstn_in),
		.cs_n_in       (cs_n_in),
		.sdi_in        (sdi_in),
		.rb_valid_in   (rb_valid),
		.rb_word_in    (rb_word),
		.word_out      (link_word),
		.bit_count_out (link_cnt),
		.frame_tog_out (link_tog),
		.sdo_out       (sdo_out),
		.sdo_oe_n_out  (sdo_oe_n_out)
	);

	// ==========================================================
	// Input synchronisers and filters
	assign raw = {link_tog, write_protect_n_in, reload_strobe_n_in, cs_n_in};

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1 <= dres_pkg::SYNC_INIT;
			s2 <= dres_pkg::SYNC_INIT;
			s3 <= dres_pkg::SYNC_INIT;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
	assign rise      = next_filt & ~filt;

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			filt <= dres_pkg::SYNC_INIT;
		end else begin
			filt <= next_filt;
		end
	end

	assign cs_rise = rise[0];
	assign pr_rise = rise[1];
	assign pr_low  = ~filt[1];
	assign wp_on   = ~filt[2];

	// ==========================================================
	// Frame acceptance
	assign clocked  = filt[3] ^ seen_tog;
	assign cmd_word = clocked ? link_word : last_word;
	assign cmd      = cmd_word[dres_pkg::CMD_LSB +: 4];
	assign addr     = cmd_word[dres_pkg::ADDR_LSB +: 4];
	assign data     = cmd_word[dres_pkg::DATA_BITS-1:0];
	assign ch       = addr[0];

	assign go = cs_rise && (state == dres_pkg::ST_IDLE) && !pr_low
		&& ((clocked && (link_cnt == 5'h00)) || (!clocked && last_ok));

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			seen_tog <= 1'b0;
		end else if (cs_rise) begin
			seen_tog <= filt[3];
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_word <= 24'h000000;
			last_ok   <= 1'b0;
		end else if (go) begin
			last_word <= cmd_word;
			last_ok   <= 1'b1;
		end
	end

	// User words at 2 to 14.
	assign store_ok = !wp_on && ((cmd == dres_pkg::CMD_STORE_WIPER)
		|| ((cmd == dres_pkg::CMD_STORE_ANY) && (addr != dres_pkg::ADDR_RSVD)));

	// ==========================================================
	// Busy sequencer
	assign load_done  = (state == dres_pkg::ST_LOAD) && (busy_cnt == '0);
	assign store_done = (state == dres_pkg::ST_STORE) && (busy_cnt == '0);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state     <= dres_pkg::ST_LOAD;
			busy_cnt  <= CNT_W'(RESTORE_CYCLES - 1);
			load_mask <= 2'h3;
			pr_pend   <= 1'b0;
		end else begin
			if (pr_rise) begin
				pr_pend <= 1'b1;
			end
			case (state)
				dres_pkg::ST_IDLE: begin
					if ((pr_rise || pr_pend) && !pr_low) begin
						state     <= dres_pkg::ST_LOAD;
						busy_cnt  <= CNT_W'(RESTORE_CYCLES - 1);
						load_mask <= 2'h3;
						pr_pend   <= 1'b0;
					end else if (go) begin
						case (dres_pkg::cmd_t'(cmd))
							dres_pkg::CMD_RESTORE_ONE: begin
								state     <= dres_pkg::ST_LOAD;
								busy_cnt  <= CNT_W'(RESTORE_CYCLES - 1);
								load_mask <= ch ? 2'h2 : 2'h1;
							end
							dres_pkg::CMD_RELOAD_ALL: begin
								state     <= dres_pkg::ST_LOAD;
								busy_cnt  <= CNT_W'(RESTORE_CYCLES - 1);
								load_mask <= 2'h3;
							end
							dres_pkg::CMD_STORE_WIPER, dres_pkg::CMD_STORE_ANY: begin
								if (store_ok) begin
									state    <= dres_pkg::ST_STORE;
									busy_cnt <= CNT_W'(STORE_CYCLES - 1);
								end
							end
							dres_pkg::CMD_READ_STORE, dres_pkg::CMD_READ_WIPER: begin
								state    <= dres_pkg::ST_READ;
								busy_cnt <= CNT_W'(READ_CYCLES - 1);
							end
							default: begin
								state <= dres_pkg::ST_IDLE;
							end
						endcase
					end
				end
				dres_pkg::ST_STORE, dres_pkg::ST_LOAD, dres_pkg::ST_READ: begin
					if (busy_cnt == '0) begin
						state <= dres_pkg::ST_IDLE;
					end else begin
						busy_cnt <= busy_cnt - CNT_W'(1);
					end
				end
				default: begin
					state <= dres_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign rdy_out      = 1'b0;
	assign rdy_oe_n_out = (state == dres_pkg::ST_IDLE);

	// ==========================================================
	// Store target capture
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_addr <= 4'h0;
			st_data <= 16'h0000;
		end else if (go && store_ok && (state == dres_pkg::ST_IDLE)) begin
			if (cmd == dres_pkg::CMD_STORE_WIPER || addr < dres_pkg::USER_FIRST) begin
				st_addr <= {3'h0, ch};
				st_data <= {6'h00, wiper[ch]};
			end else begin
				st_addr <= addr;
				st_data <= data;
			end
		end
	end

	// ==========================================================
	// Nonvolatile store
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < dres_pkg::STORE_WORDS; i++) begin
				store[i] <= (i < dres_pkg::CHANNELS) ? dres_pkg::STORE_MID : dres_pkg::STORE_INIT;
			end
		end else if (store_done && (st_addr <= dres_pkg::USER_LAST)) begin
			store[st_addr] <= st_data;
		end
	end

	// ==========================================================
	// Wiper registers
	generate
		for (genvar g = 0; g < dres_pkg::CHANNELS; g++) begin : g_wiper
			always_ff @(posedge mclk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					wiper[g] <= dres_pkg::WIPER_MID;
				end else if (pr_low) begin
					wiper[g] <= dres_pkg::WIPER_MID;
				end else if (load_done && load_mask[g]) begin
					wiper[g] <= store[g][dres_pkg::WIPER_BITS-1:0];
				end else if (go && !wp_on && hits(cmd, ch, 1'(g))) begin
					wiper[g] <= wiper_op(cmd, wiper[g], data);
				end
			end
		end
	endgenerate

	assign wiper0_out = wiper[0];
	assign wiper1_out = wiper[1];

	// ==========================================================
	// Readback word
	// Readback of store or wiper.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rb_word  <= 24'h000000;
			rb_valid <= 1'b0;
		end else if (go) begin
			if (cmd == dres_pkg::CMD_READ_STORE) begin
				rb_word  <= {cmd, addr, store[addr]};
				rb_valid <= 1'b1;
			end else if (cmd == dres_pkg::CMD_READ_WIPER) begin
				rb_word  <= {cmd, addr, 6'h00, wiper[ch]};
				rb_valid <= 1'b1;
			end else begin
				rb_valid <= 1'b0;
			end
		end
	end

endmodule : digital_resistor_serial_control

`default_nettype wire

//--- logic/dres_pkg.sv
/*
 * Constants, command codes and busy states of the dual-channel resistor controller.
 * Assumes a 20 MHz system clock and a host-driven serial link.
 */
package dres_pkg;

	// ==========================================================
	// Serial word layout
	localparam int          WORD_BITS    = 24;
	localparam int          CMD_LSB      = 20;
	localparam int          ADDR_LSB     = 16;
	localparam int          DATA_BITS    = 16;
	localparam int          WIPER_BITS   = 10;
	localparam int          CHANNELS     = 2;
	localparam int          STORE_WORDS  = 16;

	// ==========================================================
	// Reset values and addresses
	localparam logic [9:0]  WIPER_MID    = 10'h200;
	localparam logic [9:0]  WIPER_FULL   = 10'h3ff;
	localparam logic [9:0]  WIPER_ZERO   = 10'h000;
	localparam logic [15:0] STORE_INIT   = 16'h0000;
	localparam logic [15:0] STORE_MID    = 16'h0200;
	localparam logic [3:0]  USER_FIRST   = 4'h2;
	localparam logic [3:0]  USER_LAST    = 4'he;
	localparam logic [3:0]  ADDR_RSVD    = 4'hf;
	localparam logic [3:0]  SYNC_INIT    = 4'h7;

	// ==========================================================
	// Timing
	localparam int          CLK_HZ         = 20000000;
	localparam int          STORE_TIME_MS  = 15;
	localparam int          STORE_CYCLES   = STORE_TIME_MS * (CLK_HZ / 1000);
	localparam int          RESTORE_CYCLES = 16;
	localparam int          READ_CYCLES    = 2;

	// ==========================================================
	// Command codes and busy states
	typedef enum logic [3:0] {
		CMD_NOP         = 4'h0,
		CMD_RESTORE_ONE = 4'h1,
		CMD_STORE_WIPER = 4'h2,
		CMD_STORE_ANY   = 4'h3,
		CMD_HALVE_ONE   = 4'h4,
		CMD_HALVE_ALL   = 4'h5,
		CMD_DEC_ONE     = 4'h6,
		CMD_DEC_ALL     = 4'h7,
		CMD_RELOAD_ALL  = 4'h8,
		CMD_READ_STORE  = 4'h9,
		CMD_READ_WIPER  = 4'ha,
		CMD_WRITE_WIPER = 4'hb,
		CMD_DOUBLE_ONE  = 4'hc,
		CMD_DOUBLE_ALL  = 4'hd,
		CMD_INC_ONE     = 4'he,
		CMD_INC_ALL     = 4'hf
	} cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_STORE = 2'b01,
		ST_LOAD  = 2'b10,
		ST_READ  = 2'b11
	} busy_state_t;

endpackage : dres_pkg

//--- logic/serial_link.sv
/*
 * Link-side shift register, bit counter and serial output of the controller.
 * Assumes the host stops its serial clock outside frames; chip select ends a frame.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_link (
	input  wire logic        sclk_in,
	input  wire logic        rstn_in,
	input  wire logic        cs_n_in,
	input  wire logic        sdi_in,
	input  wire logic        rb_valid_in,
	input  wire logic [23:0] rb_word_in,
	output logic      [23:0] word_out,
	output logic      [4:0]  bit_count_out,
	output logic             frame_tog_out,
	output logic             sdo_out,
	output logic             sdo_oe_n_out
);

	logic        fresh;
	logic        past;
	logic [4:0]  index;
	logic        bit_val;

	// ==========================================================
	// Frame start marker, set while chip select is high.
	always_ff @(posedge sclk_in or posedge cs_n_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fresh <= 1'b1;
		end else if (cs_n_in) begin
			fresh <= 1'b1;
		end else begin
			fresh <= 1'b0;
		end
	end

	// ==========================================================
	// Shift register.
	// Rising edge sampling.
	always_ff @(posedge sclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			word_out <= 24'h000000;
		end else begin
			word_out <= {word_out[22:0], sdi_in};
		end
	end

	// ==========================================================
	// Bit counter modulo one word.
	// Count modulo 24.
	always_ff @(posedge sclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bit_count_out <= 5'h00;
			past          <= 1'b0;
			frame_tog_out <= 1'b0;
		end else if (fresh) begin
			bit_count_out <= 5'h01;
			past          <= 1'b0;
			frame_tog_out <= ~frame_tog_out;
		end else if (bit_count_out == 5'h17) begin
			bit_count_out <= 5'h00;
			past          <= 1'b1;
		end else begin
			bit_count_out <= bit_count_out + 5'h01;
		end
	end

	// ==========================================================
	// Serial output.
	assign index = fresh ? 5'h00 : bit_count_out;

	always_comb begin
		if (rb_valid_in && !(past && !fresh)) begin
			bit_val = rb_word_in[5'h17 - index];
		end else begin
			bit_val = word_out[23];
		end
	end

	assign sdo_out      = 1'b0;
	assign sdo_oe_n_out = cs_n_in | bit_val;

endmodule : serial_link

`default_nettype wire
